// ===== core/spf_fifo_if.sv
// Push and pop handshake carrier between the controller and its FIFO memories.
interface spf_fifo_if #(parameter int W = 32, parameter int D = 4);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   logic [$clog2(D):0] level;

   modport mem (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, level);
   modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data, level);
endinterface

// ===== core/spf_fifo_mem.sv
// Small show-ahead FIFO memory with a registered head word.
module spf_fifo_mem #(parameter int W = 32, parameter int D = 4)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Freeze while the module clocks are off
   input wire logic hold,
   // Queue port
   spf_fifo_if.mem q
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW-1:0] rd_d;
   logic [AW:0] cnt_q;
   logic [W-1:0] head_q;
   logic do_push;
   logic do_pop;

   assign q.push_ready = !hold && (cnt_q != (AW+1)'(D));
   assign q.pop_valid = !hold && (cnt_q != '0);
   assign q.pop_data = head_q;
   assign q.level = cnt_q;
   assign do_push = q.push_valid && q.push_ready;
   assign do_pop = q.pop_valid && q.pop_ready;
   assign rd_d = rd_q + AW'(do_pop);

   always_ff @(posedge clk_sys)
   begin
      if (do_push)
      begin
         mem_q[wr_q] <= q.push_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q <= wr_q + AW'(do_push);
         rd_q <= rd_d;
         cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // The head register always shows the oldest word, including one written this cycle.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         head_q <= '0;
      end
      else
      begin
         head_q <= (do_push && wr_q == rd_d) ? q.push_data : mem_q[rd_d];
      end
   end

   a_level_bound: assert property (@(posedge clk_sys) disable iff (rst)
      cnt_q <= (AW+1)'(D)) else $error("fifo level above depth");
   a_push_counts: assert property (@(posedge clk_sys) disable iff (rst)
      (do_push && !do_pop) |=> cnt_q == $past(cnt_q) + 1'b1) else $error("push not counted");
endmodule

// ===== core/spf_pkg.sv
// Shared constants and types for the SPI push FIFO controller.
package spf_pkg;

   // ---------------------------------------------------------------
   // Clock and serial clock limits
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int VLP_SCK_MAX_MHZ = 2;
   localparam int VLP_HALF_MIN = (CLK_MHZ + 2 * VLP_SCK_MAX_MHZ - 1) / (2 * VLP_SCK_MAX_MHZ);
   localparam logic [7:0] VLP_HALF_M1 = 8'(VLP_HALF_MIN - 1);

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int TX_W = 32;
   localparam int RX_W = 16;
   localparam int TX_DEPTH = 4;
   localparam int RX_DEPTH = 4;
   localparam int NUM_PCS = 5;

   // ---------------------------------------------------------------
   // Command half-word fields and push word layout
   // ---------------------------------------------------------------
   localparam int CMD_LSB = 16;
   localparam int CMD_CONT_BIT = 15;
   localparam int CMD_ATTR_LSB = 12;
   localparam int CMD_PCS_LSB = 0;
   localparam logic [15:0] CMD_RST = 16'h0000;
   localparam logic [3:0] BE_FULL = 4'hF;

   // ---------------------------------------------------------------
   // Status word fields
   // ---------------------------------------------------------------
   localparam int STAT_TCF = 0;
   localparam int STAT_RFOF = 1;
   localparam int STAT_TFUF = 2;
   localparam int STAT_TXLVL = 3;
   localparam int STAT_RXLVL = 6;
   localparam int STAT_BUSY = 9;
   localparam logic [2:0] STICKY_RST = 3'h0;

   // Synchroniser reset levels, ordered {sdi, ss_n, sck}.
   localparam logic [2:0] PIN_RST = 3'h2;

   typedef enum logic [2:0] {LP_RUN, LP_WAIT, LP_STOP, LP_VERY_LOW_POWER_RUN, LP_VERY_LOW_POWER_WAIT, LP_VERY_LOW_POWER_STOP} spf_lp_t;

   typedef enum logic [1:0] {S_IDLE, S_LEAD, S_SHIFT, S_TRAIL} spf_state_t;

   typedef struct packed {
      logic [3:0] fsz;
      logic cpol;
      logic cpha;
      logic lsbfe;
      logic [7:0] br;
      logic [3:0] lead;
      logic [3:0] trail;
   } spf_attr_t;

endpackage

// ===== core/spf_push_fifo_cfg.sv
// SPI controller with push FIFO command merging, attribute sets and power-state gating.
// Notes on behaviour
// - The serial clock half period is at least one bus clock, so the divide ratio is at least two.
// - Only two attribute sets exist; a command that names a higher set uses the low index bit.
// - In master mode the chosen set gives frame size, phase, polarity, bit order, rate and delays.
// - In slave mode only the first set is used, and only its size, phase and polarity fields.
// - The transmit FIFO holds four combined command and data words.
// - Received frames of up to sixteen bits go into a four-entry receive FIFO.
// - Five active-low chip select outputs are provided; small packages bond out only the low four.
// - In very-low-power run and wait the serial clock is held to at most 2 MHz.
// - In stop and very-low-power stop all state freezes and no transfer runs.
// - The doze output is high exactly in wait and very-low-power wait.
// - All event flags are ORed onto one interrupt request.
// - A full-word push write enqueues all 32 bits as one entry.
// - A narrow data write enqueues the data with the stored command half-word.
// - A narrow command write only updates the stored command half-word.
module spf_push_fifo_cfg
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Mode and power
   input wire logic master_en,
   input wire logic halt,
   input wire logic doze_stop_en,
   input wire spf_pkg::spf_lp_t lp_mode,
   output logic doze,
   // Transfer attribute sets
   input wire spf_pkg::spf_attr_t attr_set0,
   input wire spf_pkg::spf_attr_t attr_set1,
   // Push register writes
   input wire logic push_we,
   input wire logic [3:0] push_be,
   input wire logic [31:0] push_wdata,
   output logic push_ready,
   // Receive data
   input wire logic rx_pop,
   output logic rx_valid,
   output logic [15:0] rx_data,
   // Status and interrupt
   input wire logic [2:0] status_clr,
   output logic [9:0] module_status_register,
   output logic irq,
   // Serial pins
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe,
   input wire logic ss_n_i,
   output logic [4:0] peripheral_chip_select_n,
   output logic pcs_oe
);
   spf_fifo_if #(.W(spf_pkg::TX_W), .D(spf_pkg::TX_DEPTH)) txq ();
   spf_fifo_if #(.W(spf_pkg::RX_W), .D(spf_pkg::RX_DEPTH)) rxq ();

   logic frozen;
   logic vlp;
   logic [15:0] cmd_q;
   spf_pkg::spf_state_t state_q;
   spf_pkg::spf_attr_t attr_q;
   spf_pkg::spf_attr_t attr_c;
   spf_pkg::spf_attr_t attr_sel;
   logic [15:0] fr_cmd_q;
   logic cont_q;
   logic [7:0] div_q;
   logic [7:0] half_m1;
   logic tick;
   logic [4:0] edge_q;
   logic sck_q;
   logic [4:0] pcs_q;
   logic [15:0] tx_sr_q;
   logic [15:0] rx_sr_q;
   logic [15:0] rx_new;
   logic [3:0] bit_q;
   logic skip_q;
   logic [2:0] sticky_q;
   logic [2:0] pin_raw;
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] flt_q;
   logic sck_fp_q;
   logic ss_fp_q;
   logic m_start;
   logic s_active;
   logic s_start;
   logic ev;
   logic ev_lead;
   logic sample;
   logic shift;
   logic done;
   logic s_reload;

   // ---------------------------------------------------------------
   // Power states
   // ---------------------------------------------------------------
   assign frozen = (lp_mode == spf_pkg::LP_STOP) || (lp_mode == spf_pkg::LP_VERY_LOW_POWER_STOP);
   assign vlp = (lp_mode == spf_pkg::LP_VERY_LOW_POWER_RUN) || (lp_mode == spf_pkg::LP_VERY_LOW_POWER_WAIT);
   assign doze = (lp_mode == spf_pkg::LP_WAIT) || (lp_mode == spf_pkg::LP_VERY_LOW_POWER_WAIT);

   // ---------------------------------------------------------------
   // FIFO memories
   // ---------------------------------------------------------------
   spf_fifo_mem #(.W(spf_pkg::TX_W), .D(spf_pkg::TX_DEPTH)) u_txq (
      .clk_sys(clk_sys), .rst(rst), .hold(frozen), .q(txq.mem));
   spf_fifo_mem #(.W(spf_pkg::RX_W), .D(spf_pkg::RX_DEPTH)) u_rxq (
      .clk_sys(clk_sys), .rst(rst), .hold(frozen), .q(rxq.mem));

   // ---------------------------------------------------------------
   // Push register merge
   // ---------------------------------------------------------------
   assign txq.push_valid = push_we && (|push_be[1:0]);
   assign txq.push_data = (push_be == spf_pkg::BE_FULL) ? push_wdata
      : {cmd_q, push_be[1] ? push_wdata[15:8] : 8'h00, push_be[0] ? push_wdata[7:0] : 8'h00};
   assign push_ready = txq.push_ready;

   // Command bytes are refused together with a data half that finds the FIFO full.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cmd_q <= spf_pkg::CMD_RST;
      end
      else if (push_we && !frozen && (txq.push_ready || !(|push_be[1:0])))
      begin
         if (push_be[2])
         begin
            cmd_q[7:0] <= push_wdata[23:16];
         end
         if (push_be[3])
         begin
            cmd_q[15:8] <= push_wdata[31:24];
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   assign pin_raw = {sdi_i, ss_n_i, sck_i};

   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_sync
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
            begin
               s1_q[i] <= spf_pkg::PIN_RST[i];
               s2_q[i] <= spf_pkg::PIN_RST[i];
               s3_q[i] <= spf_pkg::PIN_RST[i];
               flt_q[i] <= spf_pkg::PIN_RST[i];
            end
            else if (!frozen)
            begin
               s1_q[i] <= pin_raw[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               flt_q[i] <= (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Timing and master sequencer
   // ---------------------------------------------------------------
   assign attr_sel = txq.pop_data[spf_pkg::CMD_LSB + spf_pkg::CMD_ATTR_LSB] ? attr_set1 : attr_set0;
   assign attr_c = master_en ? attr_q : attr_set0;
   assign half_m1 = (vlp && attr_q.br < spf_pkg::VLP_HALF_M1) ? spf_pkg::VLP_HALF_M1 : attr_q.br;
   assign tick = (div_q == half_m1);
   // Without continuous select the selects go high for one cycle before the next frame.
   assign m_start = master_en && !frozen && !halt && !(doze && doze_stop_en)
      && state_q == spf_pkg::S_IDLE && txq.pop_valid && (cont_q || pcs_q == 5'h00);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_q <= spf_pkg::S_IDLE;
         attr_q <= '0;
         fr_cmd_q <= spf_pkg::CMD_RST;
         cont_q <= 1'b0;
         div_q <= '0;
         edge_q <= '0;
         sck_q <= 1'b0;
         pcs_q <= '0;
      end
      else if (!frozen)
      begin
         div_q <= (tick || state_q == spf_pkg::S_IDLE) ? 8'h00 : div_q + 8'h01;
         unique case (state_q)
            spf_pkg::S_IDLE:
            begin
               edge_q <= '0;
               if (m_start)
               begin
                  attr_q <= attr_sel;
                  fr_cmd_q <= txq.pop_data[31:16];
                  pcs_q <= txq.pop_data[spf_pkg::CMD_LSB + spf_pkg::CMD_PCS_LSB +: 5];
                  sck_q <= attr_sel.cpol;
                  state_q <= spf_pkg::S_LEAD;
               end
               else
               begin
                  sck_q <= attr_c.cpol;
                  if (!cont_q || !master_en)
                  begin
                     pcs_q <= '0;
                  end
               end
            end
            spf_pkg::S_LEAD:
            begin
               if (tick)
               begin
                  edge_q <= (edge_q == {1'b0, attr_q.lead}) ? 5'h00 : edge_q + 5'h01;
                  if (edge_q == {1'b0, attr_q.lead})
                  begin
                     state_q <= spf_pkg::S_SHIFT;
                  end
               end
            end
            spf_pkg::S_SHIFT:
            begin
               if (tick)
               begin
                  sck_q <= !sck_q;
                  edge_q <= (edge_q == {attr_q.fsz, 1'b1}) ? 5'h00 : edge_q + 5'h01;
                  if (edge_q == {attr_q.fsz, 1'b1})
                  begin
                     state_q <= spf_pkg::S_TRAIL;
                  end
               end
            end
            spf_pkg::S_TRAIL:
            begin
               if (tick)
               begin
                  edge_q <= edge_q + 5'h01;
                  if (edge_q == {1'b0, attr_q.trail})
                  begin
                     cont_q <= fr_cmd_q[spf_pkg::CMD_CONT_BIT];
                     state_q <= spf_pkg::S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Shared shift datapath for master and slave
   // ---------------------------------------------------------------
   assign s_active = !master_en && !frozen && !flt_q[1];
   assign s_start = !master_en && !frozen && ss_fp_q && !flt_q[1];
   assign ev = master_en ? (state_q == spf_pkg::S_SHIFT && tick && !frozen)
      : (s_active && flt_q[0] != sck_fp_q);
   assign ev_lead = master_en ? !edge_q[0] : (sck_fp_q == attr_set0.cpol);
   assign sample = ev && (ev_lead != attr_c.cpha);
   assign shift = ev && (ev_lead == attr_c.cpha);
   assign done = sample && (bit_q == attr_c.fsz);
   assign s_reload = s_start || (done && !master_en);
   assign txq.pop_ready = m_start || s_reload;

   always_comb
   begin
      if (attr_c.lsbfe && master_en)
      begin
         rx_new = {1'b0, rx_sr_q[15:1]};
         rx_new[attr_c.fsz] = flt_q[2];
      end
      else
      begin
         rx_new = {rx_sr_q[14:0], flt_q[2]};
      end
      rx_new = rx_new & (16'hFFFF >> (4'hF - attr_c.fsz));
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         tx_sr_q <= '0;
         rx_sr_q <= '0;
         bit_q <= '0;
         skip_q <= 1'b0;
         sck_fp_q <= 1'b0;
         ss_fp_q <= 1'b1;
      end
      else if (!frozen)
      begin
         sck_fp_q <= flt_q[0];
         ss_fp_q <= flt_q[1];
         if (m_start || s_start)
         begin
            tx_sr_q <= txq.pop_valid ? txq.pop_data[15:0] : 16'h0000;
            skip_q <= master_en ? attr_sel.cpha : attr_set0.cpha;
            bit_q <= '0;
         end
         else if (sample)
         begin
            rx_sr_q <= rx_new;
            bit_q <= done ? 4'h0 : bit_q + 4'h1;
            skip_q <= done ? 1'b1 : skip_q;
            if (done && !master_en)
            begin
               tx_sr_q <= txq.pop_valid ? txq.pop_data[15:0] : 16'h0000;
            end
         end
         else if (shift)
         begin
            skip_q <= 1'b0;
            if (!skip_q)
            begin
               tx_sr_q <= (attr_c.lsbfe && master_en) ? {1'b0, tx_sr_q[15:1]} : {tx_sr_q[14:0], 1'b0};
            end
         end
      end
   end

   assign rxq.push_valid = done;
   assign rxq.push_data = rx_new;
   assign rxq.pop_ready = rx_pop;
   assign rx_valid = rxq.pop_valid;
   assign rx_data = rxq.pop_data;

   // ---------------------------------------------------------------
   // Status flags, set wins over clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sticky_q <= spf_pkg::STICKY_RST;
      end
      else if (!frozen)
      begin
         sticky_q <= (sticky_q & ~status_clr)
            | {s_reload && !txq.pop_valid, done && !rxq.push_ready, done};
      end
   end

   assign irq = |sticky_q;
   always_comb
   begin
      module_status_register = '0;
      module_status_register[spf_pkg::STAT_TCF] = sticky_q[0];
      module_status_register[spf_pkg::STAT_RFOF] = sticky_q[1];
      module_status_register[spf_pkg::STAT_TFUF] = sticky_q[2];
      module_status_register[spf_pkg::STAT_TXLVL +: 3] = txq.level;
      module_status_register[spf_pkg::STAT_RXLVL +: 3] = rxq.level;
      module_status_register[spf_pkg::STAT_BUSY] = (state_q != spf_pkg::S_IDLE);
   end

   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   assign sck_o = sck_q;
   assign sck_oe = master_en;
   assign sdo_o = (attr_c.lsbfe && master_en) ? tx_sr_q[0] : tx_sr_q[attr_c.fsz];
   assign sdo_oe = master_en ? (state_q != spf_pkg::S_IDLE) : !flt_q[1];
   assign peripheral_chip_select_n = ~pcs_q;
   assign pcs_oe = master_en;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [7:0] gap_q;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         gap_q <= '0;
      end
      else
      begin
         gap_q <= (sck_q != $past(sck_q) || gap_q == 8'hFF) ? 8'h00 : gap_q + 8'h01;
      end
   end

   a_min_divide: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == spf_pkg::S_SHIFT && $changed(sck_q)) |-> $past(tick)) else $error("sck ratio below two");
   a_vlp_clock_limit: assert property (@(posedge clk_sys) disable iff (rst)
      (vlp && state_q == spf_pkg::S_SHIFT && $past(state_q) == spf_pkg::S_SHIFT && $changed(sck_q))
      |-> gap_q >= spf_pkg::VLP_HALF_M1) else $error("sck too fast in vlp");
   a_stop_freeze: assert property (@(posedge clk_sys) disable iff (rst)
      frozen |=> $stable(state_q) && $stable(tx_sr_q) && $stable(sticky_q)) else $error("state moved in stop");
   a_doze_states: assert property (@(posedge clk_sys) disable iff (rst)
      doze == (lp_mode == spf_pkg::LP_WAIT || lp_mode == spf_pkg::LP_VERY_LOW_POWER_WAIT)) else $error("doze mismatch");
   a_irq_combined: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(sticky_q[1]) |-> irq) else $error("overflow not on irq");
   a_narrow_merge: assert property (@(posedge clk_sys) disable iff (rst)
      (push_we && push_be == 4'h3 && txq.level == '0 && txq.push_ready && !txq.pop_ready)
      |=> txq.pop_data == {$past(cmd_q), $past(push_wdata[15:0])}) else $error("merge wrong");
   a_cmd_only: assert property (@(posedge clk_sys) disable iff (rst)
      (push_we && push_be == 4'hC && !frozen && !txq.pop_ready)
      |=> txq.level == $past(txq.level) && cmd_q == $past(push_wdata[31:16])) else $error("cmd write pushed");
   a_slave_set0: assert property (@(posedge clk_sys) disable iff (rst)
      s_start |=> skip_q == $past(attr_set0.cpha)) else $error("slave not using set0");
   a_pcs_release: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == spf_pkg::S_TRAIL && $past(state_q) == spf_pkg::S_TRAIL && !frozen && tick
      && edge_q == {1'b0, attr_q.trail} && !fr_cmd_q[spf_pkg::CMD_CONT_BIT] && master_en)
      |=> ##1 (peripheral_chip_select_n == 5'h1F || $past(frozen))) else $error("pcs held");
endmodule

// ===== tb/spf_spi_peer.sv
// Behavioural SPI peripheral in mode zero that answers on two chip selects.
module spf_spi_peer
(
   // Serial pins
   input wire logic sck,
   input wire logic sdo,
   input wire logic [1:0] cs_n,
   output logic sdi,
   // Observation of the last finished frame
   output logic [7:0] got,
   output logic [1:0] sel,
   output int frames
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tx;
   logic [7:0] sh;
   logic [1:0] sel_q;
   initial
   begin
      sdi = 1'b0;
      frames = 0;
   end
   always @(negedge (&cs_n))
   begin
      tx = 8'h96;
      sh = 8'h00;
      sel_q = cs_n;
      sdi = tx[7];
   end
   always @(negedge sck)
      if (!(&cs_n))
      begin
         tx = {tx[6:0], 1'b0};
         sdi = tx[7];
      end
   always @(posedge sck)
      if (!(&cs_n))
         sh = {sh[6:0], sdo};
   // A released data line shows the inverse of its last level.
   always @(posedge (&cs_n))
   begin
      sdi = ~sdi;
      got = sh;
      sel = sel_q;
      frames = frames + 1;
   end
endmodule

// ===== tb/tb_spf_push_fifo_cfg.sv
// Self-checking bench for the SPI push FIFO controller.
module tb_spf_push_fifo_cfg;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, halt, push_we, push_ready, rx_pop, rx_valid, irq, doze;
   logic sck_o, sdo_o, sdi_i;
   logic [3:0] push_be;
   logic [31:0] push_wdata;
   logic [15:0] rx_data;
   logic [2:0] status_clr;
   logic [9:0] module_status_register;
   logic [4:0] pcs;
   logic [7:0] got;
   logic [1:0] sel;
   int frames, bad_count, check_count;
   spf_pkg::spf_lp_t lp_mode;
   spf_pkg::spf_attr_t a0, a1;

   spf_push_fifo_cfg i_spf_push_fifo_cfg (.clk_sys(clk_sys), .rst(rst), .master_en(1'b1),
      .halt(halt), .doze_stop_en(1'b0), .lp_mode(lp_mode), .doze(doze), .attr_set0(a0),
      .attr_set1(a1), .push_we(push_we), .push_be(push_be), .push_wdata(push_wdata),
      .push_ready(push_ready), .rx_pop(rx_pop), .rx_valid(rx_valid), .rx_data(rx_data),
      .status_clr(status_clr), .module_status_register(module_status_register), .irq(irq),
      .sck_i(1'b0), .sck_o(sck_o), .sck_oe(), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe(),
      .ss_n_i(1'b1), .peripheral_chip_select_n(pcs), .pcs_oe());
   spf_spi_peer i_spf_spi_peer (.sck(sck_o), .sdo(sdo_o), .cs_n(pcs[1:0]), .sdi(sdi_i),
      .got(got), .sel(sel), .frames(frames));

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic final_report;
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] exp, input logic [15:0] act);
      check_count++;
      if (act !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t exp %h got %h", $time, exp, act);
      end
   endtask
   task automatic wr(input logic [3:0] be, input logic [31:0] d);
      push_be = be;
      push_wdata = d;
      push_we = 1'b1;
      @(negedge clk_sys);
      push_we = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic t_reset;
      chk(16'h001F, pcs);
      chk(16'h0000, {irq, module_status_register});
   endtask
   // Narrow command, narrow data and full writes, then overfill the queue.
   task automatic t_fill;
      wr(4'hC, 32'h0001_0000);
      chk(16'h0000, module_status_register[5:3]);
      wr(4'h3, 32'hFFFF_00A5);
      wr(4'h1, 32'hFFFF_AB3C);
      chk(16'h0002, module_status_register[5:3]);
      wr(4'hF, 32'h1002_00C1);
      wr(4'h1, 32'h0000_0012);
      chk(16'h0004, module_status_register[5:3]);
      chk(16'h0000, push_ready);
      wr(4'h1, 32'h0000_0077);
      chk(16'h0004, module_status_register[5:3]);
   endtask
   // Each frame shows its data, select and bit order at the peer.
   task automatic t_frames;
      logic [7:0] eg [4] = '{8'hA5, 8'h3C, 8'h83, 8'h48};
      logic [1:0] es [4] = '{2'b10, 2'b10, 2'b01, 2'b01};
      int n, i, k;
      halt = 1'b0;
      for (k = 0; k < 4; k++)
      begin
         n = frames;
         for (i = 0; i < 2000 && frames == n; i++)
            @(negedge clk_sys);
         if (frames == n)
         begin
            bad_count++;
            final_report();
         end
         chk(eg[k], got);
         chk(es[k], sel);
      end
      halt = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(16'h0004, module_status_register[8:6]);
      chk(16'h0003, {irq, module_status_register[0]});
      for (k = 0; k < 4; k++)
      begin
         chk(k < 2 ? 16'h0096 : 16'h0069, rx_valid ? rx_data : 16'hDEAD);
         rx_pop = 1'b1;
         @(negedge clk_sys);
         rx_pop = 1'b0;
         @(negedge clk_sys);
      end
      status_clr = 3'h1;
      @(negedge clk_sys);
      status_clr = 3'h0;
      @(negedge clk_sys);
      chk(16'h0000, irq);
   endtask
   // One frame in very-low-power run keeps every serial clock half period at the floor.
   task automatic t_vlp;
      int n, i, run, least;
      logic last;
      n = frames;
      run = 0;
      least = 1000;
      last = sck_o;
      lp_mode = spf_pkg::LP_VERY_LOW_POWER_RUN;
      wr(4'h1, 32'h0000_005A);
      halt = 1'b0;
      for (i = 0; i < 3000 && frames == n; i++)
      begin
         @(negedge clk_sys);
         run++;
         if (sck_o != last)
         begin
            least = (run < least) ? run : least;
            run = 0;
            last = sck_o;
         end
      end
      halt = 1'b1;
      lp_mode = spf_pkg::LP_RUN;
      if (frames == n)
      begin
         bad_count++;
         final_report();
      end
      chk(16'h005A, got);
      chk(16'(spf_pkg::VLP_HALF_MIN), 16'(least));
   endtask
   // Every power state: doze flag, and a frozen queue in the stop states.
   task automatic t_power;
      int m;
      for (m = 0; m < 6; m++)
      begin
         lp_mode = spf_pkg::spf_lp_t'(m);
         @(negedge clk_sys);
         chk(m == 1 || m == 4, doze);
         if (m == 2 || m == 5)
         begin
            chk(16'h0000, push_ready);
            wr(4'h1, 32'h0000_0055);
         end
      end
      lp_mode = spf_pkg::LP_RUN;
      @(negedge clk_sys);
      chk(16'h0000, module_status_register[5:3]);
   endtask

   initial
   begin
      bad_count = 0;
      check_count = 0;
      rst = 1'b1;
      halt = 1'b1;
      lp_mode = spf_pkg::LP_RUN;
      a0 = spf_pkg::spf_attr_t'{4'h7, 1'b0, 1'b0, 1'b0, 8'h07, 4'h1, 4'h1};
      a1 = spf_pkg::spf_attr_t'{4'h7, 1'b0, 1'b0, 1'b1, 8'h07, 4'h1, 4'h1};
      push_we = 1'b0;
      push_be = 4'h0;
      push_wdata = 32'h0000_0000;
      rx_pop = 1'b0;
      status_clr = 3'h0;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      t_reset();
      t_fill();
      t_frames();
      t_vlp();
      t_power();
      final_report();
   end
endmodule
